// File: rtl/cob_defines.vh
// Constants for the communication object bank
// Assumes inclusion by bare name from rtl files
`ifndef COB_DEFINES_VH
`define COB_DEFINES_VH
`define COB_IDX_DEVTYPE 16'h1000
`define COB_IDX_ERRFLAGS 16'h1001
`define COB_IDX_ERRHIST 16'h1003
`define COB_IDX_SYNCID 16'h1005
`define COB_IDX_SYNCPER 16'h1006
`define COB_IDX_NAME 16'h1008
`define COB_IDX_HWVER 16'h1009
`define COB_IDX_FWVER 16'h100a
`define COB_PROFILE 16'h0191
`define COB_HIST_DEPTH 4'h a
`define COB_SYNCID_RST 32'h0000_0080
`define COB_SYNCID_MASK 32'h4000_07ff
`define COB_SYNCID_PRODUCE 30
`define COB_EF_VENDOR 7
`define COB_EF_COMM 4
`define COB_EF_GENERIC 0
`define COB_TYPE_MAX 8'hf0
`define COB_CYC_PER_US 8'h c8
`define COB_LIMIT_US 32'h0001_5f90
`define COB_STR_LEN 5'h10
`define COB_ST_IDLE 3'h1
`define COB_ST_SEG 3'h2
`define COB_ST_DONE 3'h4
`define COB_ST_W 3
`endif

// File: rtl/cob_object_bank.v
// Object dictionary bank: device class, error flags, error history,
// sync identifier, sync interval watchdog, and segmented id strings.
// Assumes a service-data front end that decodes index/sub-index requests.
`timescale 1ns/10ps
`default_nettype none
`include "cob_defines.vh"
module cob_object_bank (
   input wire clock,
   input wire reset,
   input wire has_dig_in,
   input wire has_dig_out,
   input wire has_ana_in,
   input wire has_ana_out,
   input wire err_event,
   input wire [15:0] err_code,
   input wire [15:0] err_add_code,
   input wire err_vendor,
   input wire err_comm,
   input wire sync_rx,
   input wire sync_pdo_active,
   input wire all_pdo_sync,
   input wire [7:0] lowest_tx_type,
   input wire req_valid,
   input wire req_write,
   input wire [15:0] req_index,
   input wire [7:0] req_sub,
   input wire [31:0] req_wdata,
   input wire seg_next,
   input wire [127:0] name_str,
   input wire [127:0] hw_str,
   input wire [127:0] fw_str,
   output reg rsp_valid,
   output reg rsp_abort,
   output reg rsp_segmented,
   output reg [7:0] rsp_byte,
   output reg rsp_byte_valid,
   output reg rsp_last,
   output reg [31:0] rsp_data,
   output reg sync_fault,
   output reg io_update
);
   ////////////////////////////////////////////////////////////////////////
   // Storage
   reg [31:0] hist_r [1:10];
   reg [3:0] hist_cnt_r;
   reg [7:0] err_flags_r;
   reg [31:0] sync_id_r;
   reg [31:0] sync_per_r;
   reg [31:0] us_cnt_r;
   reg [7:0] pre_cnt_r;
   reg [`COB_ST_W-1:0] state_r;
   reg [127:0] str_r;
   reg [4:0] seg_idx_r;
   wire hist_clear;
   wire req_take;
   wire per_set;
   wire [31:0] dev_class;
   wire [32:0] limit_us;
   wire [39:0] cycle_us;
   wire imm_ok;
   reg [31:0] rd_word;
   reg rd_ok;
   reg wr_ok;
   reg is_str;

   assign dev_class = {12'h000, has_ana_out, has_ana_in, has_dig_out, has_dig_in,
                       `COB_PROFILE};
   // Requests count only while idle; string reads hold further requests off
   assign req_take = req_valid && state_r == `COB_ST_IDLE;
   assign per_set = sync_per_r != 32'h0000_0000;
   assign hist_clear = req_take && req_write && req_index == `COB_IDX_ERRHIST && req_sub == 8'h00
                       && req_wdata == 32'h0000_0000;
   assign limit_us = {1'b0, sync_per_r} + {2'b00, sync_per_r[31:1]};
   assign cycle_us = sync_per_r * lowest_tx_type;
   assign imm_ok = all_pdo_sync && lowest_tx_type <= `COB_TYPE_MAX && per_set
                   && cycle_us < {8'h00, `COB_LIMIT_US};

   ////////////////////////////////////////////////////////////////////////
   // Error history, pushed at sub-index 1
   // An error in the same cycle wins over a clear
   genvar gi;
   generate
      for (gi = 1; gi <= `COB_HIST_DEPTH; gi = gi + 1) begin : g_hist
         if (gi == 1) begin : g_head
            always @(posedge clock) begin
               if (reset) begin
                  hist_r[gi] <= 32'h0000_0000;
               end else if (err_event) begin
                  hist_r[gi] <= {err_add_code, err_code};
               end else if (hist_clear) begin
                  hist_r[gi] <= 32'h0000_0000;
               end
            end
         end else begin : g_tail
            always @(posedge clock) begin
               if (reset) begin
                  hist_r[gi] <= 32'h0000_0000;
               end else if (err_event) begin
                  hist_r[gi] <= hist_r[gi-1];
               end else if (hist_clear) begin
                  hist_r[gi] <= 32'h0000_0000;
               end
            end
         end
      end
   endgenerate

   always @(posedge clock) begin
      if (reset) begin
         hist_cnt_r <= 4'h0;
         err_flags_r <= 8'h00;
      end else begin
         if (err_event) begin
            if (hist_cnt_r != `COB_HIST_DEPTH) begin
               hist_cnt_r <= hist_cnt_r + 4'h1;
            end else begin
               hist_cnt_r <= hist_cnt_r;
            end
            err_flags_r[`COB_EF_GENERIC] <= 1'b1;
            if (err_vendor) begin
               err_flags_r[`COB_EF_VENDOR] <= 1'b1;
            end
            if (err_comm) begin
               err_flags_r[`COB_EF_COMM] <= 1'b1;
            end
         end else if (hist_clear) begin
            hist_cnt_r <= 4'h0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sync watchdog and immediate update
   // Counts microseconds; faults once one and a half intervals pass
   always @(posedge clock) begin
      if (reset) begin
         us_cnt_r <= 32'h0000_0000;
         pre_cnt_r <= 8'h00;
         sync_fault <= 1'b0;
         io_update <= 1'b0;
      end else begin
         io_update <= sync_rx && imm_ok;
         if (sync_rx || !per_set || !sync_pdo_active) begin
            us_cnt_r <= 32'h0000_0000;
            pre_cnt_r <= 8'h00;
         end else if (pre_cnt_r == `COB_CYC_PER_US - 8'h01) begin
            pre_cnt_r <= 8'h00;
            if (us_cnt_r != 32'hffff_ffff) begin
               us_cnt_r <= us_cnt_r + 32'h0000_0001;
            end
            if ({1'b0, us_cnt_r} + 33'h0_0000_0001 >= limit_us) begin
               sync_fault <= 1'b1;
            end
         end else begin
            pre_cnt_r <= pre_cnt_r + 8'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read decode
   always @* begin
      rd_word = 32'h0000_0000;
      rd_ok = 1'b1;
      wr_ok = 1'b0;
      is_str = 1'b0;
      case (req_index)
         `COB_IDX_DEVTYPE: begin
            rd_word = dev_class;
         end
         `COB_IDX_ERRFLAGS: begin
            rd_word = {24'h00_0000, err_flags_r};
         end
         `COB_IDX_ERRHIST: begin
            if (req_sub == 8'h00) begin
               rd_word = {28'h000_0000, hist_cnt_r};
               wr_ok = req_wdata == 32'h0000_0000;
            end else if (req_sub <= {4'h0, hist_cnt_r}) begin
               rd_word = hist_r[req_sub[3:0]];
            end else begin
               rd_ok = 1'b0;
            end
         end
         `COB_IDX_SYNCID: begin
            rd_word = sync_id_r;
            wr_ok = 1'b1;
         end
         `COB_IDX_SYNCPER: begin
            rd_word = sync_per_r;
            wr_ok = 1'b1;
         end
         `COB_IDX_NAME, `COB_IDX_HWVER, `COB_IDX_FWVER: is_str = 1'b1;
         default: rd_ok = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Writes and answers
   always @(posedge clock) begin
      if (reset) begin
         sync_id_r <= `COB_SYNCID_RST;
         sync_per_r <= 32'h0000_0000;
         state_r <= `COB_ST_IDLE;
         rsp_valid <= 1'b0;
         rsp_abort <= 1'b0;
         rsp_segmented <= 1'b0;
         rsp_byte <= 8'h00;
         rsp_byte_valid <= 1'b0;
         rsp_last <= 1'b0;
         rsp_data <= 32'h0000_0000;
         str_r <= 128'h0;
         seg_idx_r <= 5'h00;
      end else begin
         rsp_valid <= 1'b0;
         rsp_byte_valid <= 1'b0;
         rsp_last <= 1'b0;
         case (state_r)
            `COB_ST_IDLE: begin
               if (req_valid) begin
                  rsp_abort <= 1'b0;
                  rsp_segmented <= 1'b0;
                  if (req_write) begin
                     rsp_valid <= 1'b1;
                     if (!wr_ok || !rd_ok) begin
                        rsp_abort <= 1'b1;
                     end else if (req_index == `COB_IDX_SYNCID) begin
                        sync_id_r <= req_wdata & `COB_SYNCID_MASK & ~(32'h1 << `COB_SYNCID_PRODUCE);
                     end else if (req_index == `COB_IDX_SYNCPER) begin
                        sync_per_r <= req_wdata;
                     end
                  end else if (is_str) begin
                     rsp_segmented <= 1'b1;
                     case (req_index)
                        `COB_IDX_NAME: begin
                           str_r <= name_str;
                        end
                        `COB_IDX_HWVER: begin
                           str_r <= hw_str;
                        end
                        default: begin
                           str_r <= fw_str;
                        end
                     endcase
                     seg_idx_r <= 5'h00;
                     state_r <= `COB_ST_SEG;
                  end else begin
                     rsp_valid <= 1'b1;
                     rsp_abort <= !rd_ok;
                     rsp_data <= rd_word; // byte 0 is bits 7:0
                  end
               end
            end
            `COB_ST_SEG: begin
               // One byte per seg_next, least significant first
               if (seg_next) begin
                  rsp_byte <= str_r[7:0];
                  str_r <= {8'h00, str_r[127:8]};
                  rsp_byte_valid <= 1'b1;
                  seg_idx_r <= seg_idx_r + 5'h01;
                  if (seg_idx_r == `COB_STR_LEN - 5'h01) begin
                     rsp_last <= 1'b1;
                     state_r <= `COB_ST_DONE;
                  end
               end
            end
            `COB_ST_DONE: begin
               rsp_valid <= 1'b1;
               state_r <= `COB_ST_IDLE;
            end
            default: state_r <= `COB_ST_IDLE;
         endcase
      end
   end
endmodule // cob_object_bank
`default_nettype wire

// File: sim/cob_master_model.sv
// Master model fetching segmented string bytes
// Assumes the bank's seg_next and rsp_byte_valid handshake
`timescale 1ns/10ps
`default_nettype none
module cob_master_model (
   input wire logic clock,
   input wire logic reset,
   input wire logic go,
   input wire logic rsp_segmented,
   input wire logic rsp_byte_valid,
   input wire logic rsp_last,
   output var logic seg_next
);
   logic busy_r;
   logic fin_r;
   // One byte request at a time, stalls while go is low
   always @(posedge clock) begin
      seg_next <= 1'b0;
      if (reset || !rsp_segmented) begin
         busy_r <= 1'b0;
         fin_r <= 1'b0;
      end else if (rsp_byte_valid) begin
         busy_r <= 1'b0;
         fin_r <= rsp_last;
      end else if (!busy_r && !fin_r && go) begin
         seg_next <= 1'b1;
         busy_r <= 1'b1;
      end
   end
endmodule // cob_master_model
`default_nettype wire

// File: sim/cob_object_bank_monitor.sv
// Assertion checker on the object bank ports
// Assumes a bind onto cob_object_bank and a single clock
`timescale 1ns/10ps
`default_nettype none
module cob_object_bank_monitor (
   input wire logic clock,
   input wire logic reset,
   input wire logic has_dig_in,
   input wire logic has_dig_out,
   input wire logic has_ana_in,
   input wire logic has_ana_out,
   input wire logic err_event,
   input wire logic all_pdo_sync,
   input wire logic [7:0] lowest_tx_type,
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic [15:0] req_index,
   input wire logic [7:0] req_sub,
   input wire logic rsp_valid,
   input wire logic rsp_abort,
   input wire logic rsp_segmented,
   input wire logic rsp_last,
   input wire logic [31:0] rsp_data,
   input wire logic sync_fault,
   input wire logic io_update
);
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   logic seen_r;
   wire logic rd = req_valid && !req_write && !rsp_segmented;
   wire logic ro = req_index == 16'h1000 || req_index == 16'h1001 || req_index >= 16'h1008;
   // Any error seen since reset
   always @(posedge clock) seen_r <= reset ? 1'b0 : seen_r | err_event;
   ////////////////////////////////////////////////////////////////////////
   a_class_word: assert property (rd && req_index == 16'h1000 |=> rsp_valid && rsp_data[15:0] == 16'h0191
      && rsp_data[31:16] == {12'h000, $past(has_ana_out), $past(has_ana_in), $past(has_dig_out), $past(has_dig_in)})
      else $error("class word wrong");
   a_ro_abort: assert property (req_valid && req_write && !rsp_segmented && ro |=> rsp_valid && rsp_abort)
      else $error("read-only write not refused");
   a_flag_bits: assert property (rd && req_index == 16'h1001 |=> rsp_data[0] == $past(seen_r)
      && (rsp_data[7:0] & 8'h6e) == 8'h00) else $error("error flags wrong");
   a_hist_empty: assert property (rd && req_index == 16'h1003 && req_sub == 8'h00 && !seen_r
      |=> rsp_data == 32'h0) else $error("history not empty");
   a_sync_top: assert property (rd && req_index == 16'h1005 |=> rsp_data[31:11] == 21'h0)
      else $error("sync id top bits set");
   a_str_seg: assert property (rd && req_index == 16'h1008 |=> rsp_segmented && !rsp_valid)
      else $error("string not segmented");
   a_last_valid: assert property (rsp_last |=> rsp_valid && !rsp_abort) else $error("no answer after last");
   a_fault_hold: assert property (sync_fault |=> sync_fault) else $error("fault dropped");
   a_io_cond: assert property (io_update |-> $past(all_pdo_sync) && $past(lowest_tx_type) <= 8'hf0)
      else $error("update without qualification");
   c_string: cover property (rsp_last);
   c_abort: cover property (rsp_valid && rsp_abort);
   c_fault: cover property ($rose(sync_fault));
endmodule // cob_object_bank_monitor
bind cob_object_bank cob_object_bank_monitor cob_object_bank_monitor_i (.*);
`default_nettype wire

// File: sim/test_cob_object_bank.sv
// Self-checking bench for the object bank
// Assumes the bank, its bound monitor and the master model
`timescale 1ns/10ps
`default_nettype none
module test_cob_object_bank;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic has_dig_in, has_dig_out, has_ana_in, has_ana_out, err_event, err_vendor, err_comm, sync_rx, go;
   logic sync_pdo_active, all_pdo_sync, req_valid, req_write, seg_next, rsp_valid, rsp_abort, rsp_segmented;
   logic rsp_byte_valid, rsp_last, sync_fault, io_update;
   logic [15:0] err_code, err_add_code, req_index;
   logic [7:0] lowest_tx_type, req_sub, rsp_byte;
   logic [31:0] req_wdata, rsp_data, rnd;
   logic [127:0] name_str, hw_str, fw_str;
   logic [33:0] e;
   logic [33:0] eq[$];
   logic [7:0] bq[$];
   logic [31:0] eh[0:10];
   int failures = 0;
   int checks = 0;
   int cyc = 0;
   int i;
   cob_object_bank cob_object_bank_i (.*);
   cob_master_model cob_master_model_i (.*);
   always #2.5 clock = ~clock;
   function automatic [31:0] lf(input [31:0] s);
      lf = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task chk(input [31:0] seen, input [31:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
      end
   endtask
   // Expectation is {compare data, abort, data}
   task req(input w, input [15:0] ix, input [7:0] sb, input [31:0] d, input [33:0] x);
      @(posedge clock) #1;
      {req_valid, req_write, req_index, req_sub, req_wdata} = {1'b1, w, ix, sb, d};
      eq.push_back(x);
      @(posedge clock) #1;
      req_valid = 1'b0;
   endtask
   task end_sim;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   always @(negedge clock) begin
      if (rsp_valid === 1'b1) begin
         e = eq.pop_front();
         chk({31'h0, rsp_abort}, {31'h0, e[32]});
         if (e[33]) chk(rsp_data, e[31:0]);
      end
      if (rsp_byte_valid === 1'b1) chk({24'h0, rsp_byte}, {24'h0, bq.pop_front()});
   end
   always @(posedge clock) begin
      cyc++;
      if (cyc == 5000) begin
         failures++;
         end_sim();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      {err_event, err_vendor, err_comm, sync_rx, go, sync_pdo_active, all_pdo_sync, req_valid} = '0;
      {req_write, err_code, err_add_code, req_index, lowest_tx_type, req_sub, req_wdata} = '0;
      rnd = 32'hb500_2b11;
      for (i = 0; i < 4; i++) begin
         rnd = lf(rnd);
         name_str[32 * i +: 32] = rnd;
      end
      hw_str = ~name_str;
      fw_str = name_str;
      {has_ana_out, has_ana_in, has_dig_out, has_dig_in} = rnd[7:4];
      repeat (4) @(posedge clock);
      #1 reset = 1'b0;
      req(0, 16'h1003, 8'h00, 0, 34'h2_0000_0000);
      req(0, 16'h1001, 8'h00, 0, 34'h2_0000_0000);
      req(0, 16'h1005, 8'h00, 0, 34'h2_0000_0080);
      req(0, 16'h1000, 8'h00, 0, {2'b10, 12'h000, rnd[7:4], 16'h0191});
      req(1, 16'h1000, 8'h00, rnd, 34'h1_0000_0000);
      req(1, 16'h1001, 8'h00, rnd, 34'h1_0000_0000);
      rnd = lf(rnd);
      req(1, 16'h1005, 8'h00, rnd | 32'hc000_0000, 34'h0);
      req(0, 16'h1005, 8'h00, 0, {2'b10, rnd & 32'h0000_07ff});
      for (i = 0; i < 11; i++) begin
         rnd = lf(rnd);
         eh[i] = rnd;
         {err_event, err_vendor, err_comm, err_add_code, err_code} = {1'b1, i == 3, i == 5, rnd};
         @(posedge clock) #1;
         err_event = 1'b0;
      end
      req(0, 16'h1001, 8'h00, 0, 34'h2_0000_0091);
      req(0, 16'h1003, 8'h00, 0, 34'h2_0000_000a);
      for (i = 1; i < 11; i++) req(0, 16'h1003, i[7:0], 0, {2'b10, eh[11 - i]});
      req(0, 16'h1003, 8'h0b, 0, 34'h1_0000_0000);
      req(1, 16'h1003, 8'h01, 0, 34'h1_0000_0000);
      req(1, 16'h1003, 8'h00, 1, 34'h1_0000_0000);
      req(1, 16'h1003, 8'h00, 0, 34'h0);
      req(0, 16'h1003, 8'h00, 0, 34'h2_0000_0000);
      req(0, 16'h1003, 8'h01, 0, 34'h1_0000_0000);
      for (i = 0; i < 16; i++) bq.push_back(name_str[8 * i +: 8]);
      req(0, 16'h1008, 8'h00, 0, 34'h0);
      for (i = 0; i < 400 && rsp_valid !== 1'b1; i++) begin
         @(posedge clock) #1;
         rnd = lf(rnd);
         go = rnd[0];
      end
      chk({31'h0, rsp_valid}, 32'h1);
      req(1, 16'h1009, 8'h00, 0, 34'h1_0000_0000);
      req(1, 16'h1006, 8'h00, 32'h4, 34'h0);
      {sync_pdo_active, all_pdo_sync, lowest_tx_type, sync_rx} = {2'b11, 8'h01, 1'b1};
      @(posedge clock) #1;
      sync_rx = 1'b0;
      for (i = 0; i < 4 && io_update !== 1'b1; i++) @(posedge clock) #1;
      chk({31'h0, io_update}, 32'h1);
      repeat (950) @(posedge clock);
      #1 chk({31'h0, sync_fault}, 32'h0);
      repeat (300) @(posedge clock);
      #1 chk({31'h0, sync_fault}, 32'h1);
      end_sim();
   end
endmodule // test_cob_object_bank
`default_nettype wire
